//--- hw/wdog_pkg.sv
// Constants and types shared by the watchdog and identity register block.
// Assumes a 10 MHz core clock and APB byte addresses of 13 bits.
`default_nettype none

package wdog_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock rates
    localparam int unsigned CORE_CLK_HZ = 10_000_000;
    localparam int unsigned LOW_POWER_CLK_HZ = 1_000;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int ADDR_W = 13;
    localparam logic [12:0] ADDR_FLASH_LIMITS = 13'h1050;
    localparam logic [12:0] ADDR_SERIAL_MID_HIGH = 13'h1058;
    localparam logic [12:0] ADDR_SERIAL_MID_LOW = 13'h105C;
    localparam logic [12:0] ADDR_SERIAL_LOW = 13'h1060;
    localparam logic [12:0] ADDR_WDOG_CONTROL = 13'h1100;
    localparam logic [12:0] ADDR_WDOG_SERVICE = 13'h1104;
    localparam logic [12:0] ADDR_EVENT_STATUS = 13'h1110;
    localparam logic [12:0] ADDR_EVENT_CLEAR = 13'h1114;
    localparam logic [12:0] ADDR_EVENT_ENABLE = 13'h1118;
    localparam logic [12:0] ADDR_WDOG_COUNT = 13'h111C;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields and reset value
    localparam int CTRL_WINDOW_BIT = 0;
    localparam int CTRL_CLKSEL_BIT = 1;
    localparam int CTRL_TSEL_LSB = 2;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'hC;
    localparam logic [1:0] TSEL_OFF = 2'h0;
    localparam logic [1:0] TSEL_SHORT = 2'h1;
    localparam logic [1:0] TSEL_MID = 2'h2;
    localparam logic [1:0] TSEL_LONG = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Timeout lengths in cycles of the selected source
    localparam int unsigned LPO_TIMEOUT_SHORT = 32;
    localparam int unsigned LPO_TIMEOUT_MID = 256;
    localparam int unsigned LPO_TIMEOUT_LONG = 1024;
    localparam int CNT_W = 19;

    ////////////////////////////////////////////////////////////////////////
    // Service unlock bytes
    localparam logic [7:0] SVC_FIRST = 8'h55;
    localparam logic [7:0] SVC_SECOND = 8'hAA;

    ////////////////////////////////////////////////////////////////////////
    // Flash limit register layout
    localparam int FLASH_B0_LSB = 24;
    localparam int FLASH_ONE_BIT = 23;
    localparam int FLASH_B1_LSB = 16;

    ////////////////////////////////////////////////////////////////////////
    // Event bits of status, clear and enable registers
    localparam int EVT_TIMEOUT_BIT = 0;
    localparam int EVT_EARLY_BIT = 1;
    localparam int EVT_W = 2;
    localparam logic [1:0] EVT_ENABLE_RESET = 2'h0;

    typedef enum logic {svc_idle, svc_armed} svc_state_type;

endpackage : wdog_pkg

`default_nettype wire

//--- hw/level_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is slow against the destination clock.
`timescale 1ns/1ns
`default_nettype none

module level_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_d;

    ////////////////////////////////////////////////////////////////////////
    // First flop feeds only the second
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_out <= sync_d;
        end
    end
endmodule : level_sync

`default_nettype wire

//--- hw/wdog_regs.sv
// Watchdog with write-once control and two-write service, plus read-only
// flash limit and unique serial registers, on an APB slave.
// Assumes one 10 MHz clock; the 1 kHz low-power clock arrives as a pin.
//
// Functional notes
// - Only the first write to the control register after reset takes effect.
// - Timeout select in bits 3-2 with the clock select sets the period; 00 disables the watchdog.
// - Timeout is 2^5, 2^8 or 2^10 low-power cycles, or 2^13, 2^16 or 2^18 bus cycles, for select 01, 10, 11.
// - Control bit 1 picks the counter clock: 0 the 1 kHz low-power clock, 1 the bus clock.
// - Control bit 0 selects windowed mode, which works only on the bus clock.
// - In windowed mode servicing is allowed once the counter is three quarters through the period.
// - Writing 0x55 then 0xAA to the service byte clears the timeout counter.
// - Flash limit bit 23 reads 1, bit 31 and bits 15-0 read 0.
// - Bits 30-24 give the first invalid address of flash block 0 with leading zeros.
// - Bits 22-16 added to the block 0 limit give the first invalid address of flash block 1.
// - The three serial registers are read-only; mid-high holds 16 bits and reads 0 above.
`timescale 1ns/1ns
`default_nettype none

module wdog_regs #(
    parameter int unsigned BUS_TIMEOUT_SHORT = 8192,
    parameter int unsigned BUS_TIMEOUT_MID = 65536,
    parameter int unsigned BUS_TIMEOUT_LONG = 262144,
    parameter logic [6:0] FLASH_BLOCK0_LIMIT = 7'h10,
    parameter logic [6:0] FLASH_BLOCK1_LIMIT = 7'h10,
    // Serial values are arbitrary
    parameter logic [15:0] SERIAL_MID_HIGH = 16'h1234,
    parameter logic [31:0] SERIAL_MID_LOW = 32'h5678_9ABC,
    parameter logic [31:0] SERIAL_LOW = 32'hDEF0_1357
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [wdog_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_power_clock,
    output logic wdog_reset,
    output logic irq
);
    import wdog_pkg::*;

    logic lpo_sync;
    logic lpo_prev_q, lpo_prev_d;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic ctrl_locked_q, ctrl_locked_d;
    logic [CNT_W-1:0] count_q, count_d;
    svc_state_type svc_q, svc_d;
    logic [EVT_W-1:0] status_q, status_d;
    logic [EVT_W-1:0] evt_en_q, evt_en_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d, wdog_reset_d, irq_d;
    logic setup, wr_en, wr_svc, mapped;
    logic lpo_rise, tick, enabled, windowed, complete, service_ok;
    logic timeout_evt, early_evt;
    logic [CNT_W-1:0] limit, window_start;
    logic [31:0] rd_mux;
    logic [EVT_W-1:0] events;

    ////////////////////////////////////////////////////////////////////////
    // Low-power clock edge, detected only after the synchroniser
    level_sync u_lpo_sync (
        .clk(core_clk),
        .rst(rst),
        .async_in(low_power_clock),
        .sync_out(lpo_sync)
    );

    assign lpo_rise = lpo_sync & ~lpo_prev_q;
    assign lpo_prev_d = lpo_sync;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; data is prepared in setup so the access needs no wait
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign wr_svc = wr_en && (paddr == ADDR_WDOG_SERVICE);

    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADDR_FLASH_LIMITS:
            begin
                rd_mux[FLASH_B0_LSB +: 7] = FLASH_BLOCK0_LIMIT;
                rd_mux[FLASH_ONE_BIT] = 1'b1;
                rd_mux[FLASH_B1_LSB +: 7] = FLASH_BLOCK1_LIMIT;
            end
            ADDR_SERIAL_MID_HIGH: rd_mux[15:0] = SERIAL_MID_HIGH;
            ADDR_SERIAL_MID_LOW: rd_mux = SERIAL_MID_LOW;
            ADDR_SERIAL_LOW: rd_mux = SERIAL_LOW;
            ADDR_WDOG_CONTROL: rd_mux[CTRL_W-1:0] = ctrl_q;
            ADDR_WDOG_SERVICE, ADDR_EVENT_CLEAR: rd_mux = 32'h0000_0000;
            ADDR_EVENT_STATUS: rd_mux[EVT_W-1:0] = status_q;
            ADDR_EVENT_ENABLE: rd_mux[EVT_W-1:0] = evt_en_q;
            ADDR_WDOG_COUNT: rd_mux[CNT_W-1:0] = count_q;
            default: mapped = 1'b0;
        endcase
    end

    always_comb
    begin
        pready_d = setup;
        pslverr_d = setup && !mapped;
        prdata_d = (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-once control and event enable
    always_comb
    begin
        ctrl_d = ctrl_q;
        ctrl_locked_d = ctrl_locked_q;
        evt_en_d = evt_en_q;
        if (wr_en && paddr == ADDR_WDOG_CONTROL && !ctrl_locked_q)
        begin
            ctrl_d = pwdata[CTRL_W-1:0];
            ctrl_locked_d = 1'b1;
        end
        if (wr_en && paddr == ADDR_EVENT_ENABLE)
        begin
            evt_en_d = pwdata[EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Period and window from the control fields
    assign enabled = ctrl_q[CTRL_TSEL_LSB +: 2] != TSEL_OFF;
    assign windowed = ctrl_q[CTRL_WINDOW_BIT] && ctrl_q[CTRL_CLKSEL_BIT];
    assign tick = ctrl_q[CTRL_CLKSEL_BIT] ? 1'b1 : lpo_rise;

    always_comb
    begin
        limit = CNT_W'(LPO_TIMEOUT_LONG);
        unique case (ctrl_q[CTRL_TSEL_LSB +: 2])
            TSEL_SHORT: limit = ctrl_q[CTRL_CLKSEL_BIT] ? CNT_W'(BUS_TIMEOUT_SHORT) : CNT_W'(LPO_TIMEOUT_SHORT);
            TSEL_MID: limit = ctrl_q[CTRL_CLKSEL_BIT] ? CNT_W'(BUS_TIMEOUT_MID) : CNT_W'(LPO_TIMEOUT_MID);
            TSEL_LONG: limit = ctrl_q[CTRL_CLKSEL_BIT] ? CNT_W'(BUS_TIMEOUT_LONG) : CNT_W'(LPO_TIMEOUT_LONG);
            TSEL_OFF: limit = CNT_W'(LPO_TIMEOUT_LONG);
        endcase
        window_start = limit - (limit >> 2);
    end

    ////////////////////////////////////////////////////////////////////////
    // Service unlock sequence; a stray byte other than 0x55 drops the half-done sequence
    always_comb
    begin
        svc_d = svc_q;
        complete = 1'b0;
        unique case (svc_q)
            svc_idle:
            begin
                if (wr_svc && pwdata[7:0] == SVC_FIRST)
                begin
                    svc_d = svc_armed;
                end
            end
            svc_armed:
            begin
                if (wr_svc)
                begin
                    complete = pwdata[7:0] == SVC_SECOND;
                    svc_d = (pwdata[7:0] == SVC_FIRST) ? svc_armed : svc_idle;
                end
            end
        endcase
    end

    // Early service in windowed mode counts as a fault, not a service
    assign service_ok = enabled && complete && (!windowed || count_q >= window_start);
    assign early_evt = enabled && complete && windowed && count_q < window_start;

    ////////////////////////////////////////////////////////////////////////
    // Timeout counter; >= guards against a count left above a new limit
    assign timeout_evt = enabled && tick && !service_ok && !early_evt && count_q >= limit - 1'b1;

    always_comb
    begin
        count_d = count_q;
        if (!enabled || service_ok || early_evt || timeout_evt)
        begin
            count_d = '0;
        end
        else if (tick)
        begin
            count_d = count_q + 1'b1;
        end
        wdog_reset_d = timeout_evt || early_evt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events; a new event wins over a clear in the same cycle
    always_comb
    begin
        events = '0;
        events[EVT_TIMEOUT_BIT] = timeout_evt;
        events[EVT_EARLY_BIT] = early_evt;
        status_d = status_q;
        if (wr_en && paddr == ADDR_EVENT_CLEAR)
        begin
            status_d = status_q & ~pwdata[EVT_W-1:0];
        end
        status_d = status_d | events;
        irq_d = |(status_d & evt_en_d);
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            lpo_prev_q <= 1'b0;
            ctrl_q <= CTRL_RESET;
            ctrl_locked_q <= 1'b0;
            count_q <= '0;
            svc_q <= svc_idle;
            status_q <= '0;
            evt_en_q <= EVT_ENABLE_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            wdog_reset <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            lpo_prev_q <= lpo_prev_d;
            ctrl_q <= ctrl_d;
            ctrl_locked_q <= ctrl_locked_d;
            count_q <= count_d;
            svc_q <= svc_d;
            status_q <= status_d;
            evt_en_q <= evt_en_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            wdog_reset <= wdog_reset_d;
            irq <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    ctrl_write_once_a: assert property (ctrl_locked_q && wr_en && paddr == ADDR_WDOG_CONTROL |=> $stable(ctrl_q))
        else $error("control changed after first write");
    wdog_disabled_a: assert property (!enabled |=> count_q == '0 && !wdog_reset)
        else $error("disabled watchdog counted or fired");
    lpo_short_limit_a: assert property (timeout_evt && !ctrl_q[CTRL_CLKSEL_BIT]
        && ctrl_q[CTRL_TSEL_LSB +: 2] == TSEL_SHORT |-> count_q >= CNT_W'(LPO_TIMEOUT_SHORT - 1))
        else $error("short low-power timeout fired early");
    bus_clock_count_a: assert property (ctrl_locked_q && enabled && ctrl_q[CTRL_CLKSEL_BIT] && !wr_svc
        && !timeout_evt |=> count_q == $past(count_q) + 1'b1)
        else $error("bus clock counter missed a cycle");
    lpo_hold_count_a: assert property (ctrl_locked_q && enabled && !ctrl_q[CTRL_CLKSEL_BIT] && !lpo_rise
        && !wr_svc |=> $stable(count_q))
        else $error("counter moved without low-power edge");
    window_bus_only_a: assert property (early_evt |-> ctrl_q[CTRL_CLKSEL_BIT] && ctrl_q[CTRL_WINDOW_BIT])
        else $error("window fault outside bus clock windowed mode");
    window_open_a: assert property (complete && enabled && windowed && count_q >= window_start
        |=> count_q == '0 && !wdog_reset)
        else $error("service in open window not accepted");
    service_clear_a: assert property (svc_q == svc_armed && wr_svc && pwdata[7:0] == SVC_SECOND && enabled && !windowed
        |=> count_q == '0 ##1 !wdog_reset)
        else $error("service sequence did not clear counter");
    flash_reserved_a: assert property (psel && penable && !pwrite && paddr == ADDR_FLASH_LIMITS
        |-> prdata[23] && !prdata[31] && prdata[15:0] == 16'h0000)
        else $error("flash limit reserved bits wrong");
    flash_fields_a: assert property (psel && penable && !pwrite && paddr == ADDR_FLASH_LIMITS
        |-> prdata[30:24] == FLASH_BLOCK0_LIMIT && prdata[22:16] == FLASH_BLOCK1_LIMIT)
        else $error("flash limit fields wrong");
    serial_mid_high_a: assert property (psel && penable && !pwrite && paddr == ADDR_SERIAL_MID_HIGH
        |-> prdata == {16'h0000, SERIAL_MID_HIGH})
        else $error("mid-high serial read wrong");
    timeout_reset_a: assert property (timeout_evt |=> wdog_reset && count_q == '0 ##1 !wdog_reset)
        else $error("timeout did not give one reset pulse");

    status_sticky_a: assert property (timeout_evt |=> status_q[EVT_TIMEOUT_BIT])
        else $error("timeout event not recorded");
    irq_level_a: assert property (irq == |(status_q & evt_en_q))
        else $error("interrupt level disagrees with enabled status");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    apb_idle_a: assert property (!(psel && !penable) |=> !pready)
        else $error("ready outside access cycle");

    timeout_seen_c: cover property (timeout_evt);
    window_open_c: cover property (service_ok && windowed);
    service_seen_c: cover property (service_ok);
    early_seen_c: cover property (early_evt);
    locked_write_c: cover property (ctrl_locked_q && wr_en && paddr == ADDR_WDOG_CONTROL);
endmodule : wdog_regs

`default_nettype wire

//--- bench/watchdog_ctrl_and_flash_id_regs_tb_top.sv
// Self-checking bench for the watchdog and identity register block.
// Assumes wdog_regs with shortened bus timeouts; the bench is the APB master.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))

module watchdog_ctrl_and_flash_id_regs_tb_top;
    import wdog_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Serial values are arbitrary; short timeouts keep the run brief
    localparam logic [15:0] SER_MH = 16'hA5C3;
    localparam logic [31:0] SER_ML = 32'h0F1E_2D3C;
    localparam logic [31:0] SER_L = 32'h4B5A_6978;
    localparam int LIMIT = 20000;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic low_power_clock = 1'b0;
    logic lpo_run = 1'b0;
    logic [12:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wdog_reset;
    logic irq;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int pulses = 0;
    int gap = 0;
    int last = 0;
    int lpo_div = 0;
    int p;

    wdog_regs #(.BUS_TIMEOUT_SHORT(64), .BUS_TIMEOUT_MID(128), .BUS_TIMEOUT_LONG(256),
        .FLASH_BLOCK0_LIMIT(7'h10), .FLASH_BLOCK1_LIMIT(7'h08),
        .SERIAL_MID_HIGH(SER_MH), .SERIAL_MID_LOW(SER_ML), .SERIAL_LOW(SER_L)) dut (
        .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_power_clock(low_power_clock), .wdog_reset(wdog_reset), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end

    // Pulse monitor and run ceiling; the gap between pulses gives the period
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (wdog_reset === 1'b1)
        begin
            pulses <= pulses + 1;
            gap <= cyc - last;
            last <= cyc;
        end
        if (cyc == LIMIT)
        begin
            num_errors++;
            end_sim();
        end
    end

    // Slow low-power clock, edge aligned to the core clock so periods are exact
    always @(posedge core_clk)
    begin
        lpo_div <= (lpo_run && lpo_div < 4) ? lpo_div + 1 : 0;
        if (lpo_run && lpo_div == 4)
            low_power_clock <= ~low_power_clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK("pready wait", 1, n);
    endtask : apb

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input string n, input logic [12:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(n, e, rd);
        `CHK("slave error", 0, err);
    endtask : rd_chk

    task automatic service();
        wr(ADDR_WDOG_SERVICE, 32'h0000_0055);
        wr(ADDR_WDOG_SERVICE, 32'h0000_00AA);
    endtask : service

    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        lpo_run <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic wait_pulse();
        int n;
        int q;
        n = 0;
        q = pulses;
        while (pulses == q && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        `CHK("pulse seen", 1, n < 3000);
        if (n >= 3000)
            end_sim();
    endtask : wait_pulse

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        do_reset();
        rd_chk("control reset", ADDR_WDOG_CONTROL, 32'h0000_000C);
        rd_chk("flash limits", ADDR_FLASH_LIMITS, 32'h1088_0000);
        wr(ADDR_SERIAL_MID_HIGH, 32'hFFFF_FFFF);
        wr(ADDR_SERIAL_MID_LOW, 32'hFFFF_FFFF);
        wr(ADDR_SERIAL_LOW, 32'h0000_0000);
        rd_chk("serial mid high", ADDR_SERIAL_MID_HIGH, {16'h0000, SER_MH});
        rd_chk("serial mid low", ADDR_SERIAL_MID_LOW, SER_ML);
        rd_chk("serial low", ADDR_SERIAL_LOW, SER_L);
        apb(1'b0, 13'h0FF0, 32'h0000_0000);
        `CHK("unmapped error", 1, err);
        `CHK("unmapped data", 0, rd);
        // Bus clock period for every enabled timeout select
        for (int t = 1; t < 4; t++)
        begin
            do_reset();
            wr(ADDR_WDOG_CONTROL, 32'(t << 2) | 32'h0000_0002);
            wait_pulse();
            wait_pulse();
            `CHK("bus period", 32 << t, gap);
        end
        // Write-once control, interrupt, service and aborted service
        do_reset();
        wr(ADDR_WDOG_CONTROL, 32'h0000_0006);
        wr(ADDR_WDOG_CONTROL, 32'h0000_000F);
        rd_chk("control locked", ADDR_WDOG_CONTROL, 32'h0000_0006);
        wr(ADDR_EVENT_ENABLE, 32'h0000_0001);
        wait_pulse();
        repeat (2) @(posedge core_clk);
        `CHK("irq raised", 1, irq);
        rd_chk("timeout status", ADDR_EVENT_STATUS, 32'h0000_0001);
        wr(ADDR_EVENT_CLEAR, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        `CHK("irq cleared", 0, irq);
        wait_pulse();
        wr(ADDR_EVENT_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge core_clk);
        `CHK("irq masked", 0, irq);
        repeat (20) @(posedge core_clk);
        service();
        apb(1'b0, ADDR_WDOG_COUNT, 32'h0000_0000);
        `CHK("count after service", 1, rd < 32'h0000_0006);
        repeat (20) @(posedge core_clk);
        wr(ADDR_WDOG_SERVICE, 32'h0000_0055);
        wr(ADDR_WDOG_SERVICE, 32'h0000_0012);
        wr(ADDR_WDOG_SERVICE, 32'h0000_00AA);
        apb(1'b0, ADDR_WDOG_COUNT, 32'h0000_0000);
        `CHK("aborted service", 1, rd > 32'h0000_0014);
        // Windowed mode: early service faults, late service clears
        do_reset();
        wr(ADDR_WDOG_CONTROL, 32'h0000_000F);
        p = pulses;
        service();
        repeat (4) @(posedge core_clk);
        `CHK("early service fault", p + 1, pulses);
        rd_chk("early status", ADDR_EVENT_STATUS, 32'h0000_0002);
        repeat (200) @(posedge core_clk);
        p = pulses;
        service();
        repeat (4) @(posedge core_clk);
        `CHK("late service", p, pulses);
        apb(1'b0, ADDR_WDOG_COUNT, 32'h0000_0000);
        `CHK("window clear", 1, rd < 32'h0000_000A);
        // Timeout select 00 keeps the counter still
        do_reset();
        wr(ADDR_WDOG_CONTROL, 32'h0000_0002);
        p = pulses;
        repeat (300) @(posedge core_clk);
        `CHK("disabled pulses", p, pulses);
        rd_chk("disabled count", ADDR_WDOG_COUNT, 32'h0000_0000);
        // Low-power clock: window bit has no effect, period counts slow edges
        do_reset();
        wr(ADDR_WDOG_CONTROL, 32'h0000_0005);
        lpo_run <= 1'b1;
        p = pulses;
        service();
        repeat (4) @(posedge core_clk);
        `CHK("no window on slow clock", p, pulses);
        wait_pulse();
        wait_pulse();
        `CHK("slow clock period", 320, gap);
        end_sim();
    end

endmodule : watchdog_ctrl_and_flash_id_regs_tb_top

`default_nettype wire
